// >>> rtl/sstc_defines.vh
/*
 * constants of the safe-stop terminal configuration block: register map,
 * field positions, reset values and terminal function codes.
 * assumes inclusion by rtl/sstc_top.v only; definitions only.
 */
`ifndef SSTC_DEFINES_VH
`define SSTC_DEFINES_VH

// ==========================================================
// register offsets (byte addresses)
`define SSTC_OFS_CTRL      12'h000
`define SSTC_OFS_STATUS    12'h004
`define SSTC_OFS_IRQ_STAT  12'h008
`define SSTC_OFS_IRQ_MASK  12'h00c
`define SSTC_OFS_KEY_CLR   12'h010
`define SSTC_TERM_REGION   6'h01

// ==========================================================
// field positions
`define SSTC_CTRL_COPY_BIT   0
`define SSTC_ST_TRIP_BIT     0
`define SSTC_ST_SW_BIT       1
`define SSTC_ST_GATE_BIT     2
`define SSTC_ST_EVAL_BIT     3
`define SSTC_IRQ_TRIP_BIT    0
`define SSTC_IRQ_COPY_BIT    1
`define SSTC_IRQ_REFUSE_BIT  2
`define SSTC_IRQ_W           3

// ==========================================================
// function and polarity codes
`define SSTC_FN_RESET      8'h12
`define SSTC_FN_JOG        8'h06
`define SSTC_FN_ESTOP      8'h40
`define SSTC_FN_NONE       8'hff
`define SSTC_POL_NO        8'h00
`define SSTC_POL_NC        8'h01
`define SSTC_TRIP_CODE     8'h25

// ==========================================================
// reset values
`define SSTC_RST_FN_OTHER  8'hff
`define SSTC_RST_MASK      3'h0

`endif

// >>> rtl/sstc_term_eval.v
/*
 * one input terminal: applies the polarity code to the raw level.
 * assumes the raw level is synchronous to the clock of the caller.
 */
`timescale 1ns/10ps
module sstc_term_eval (
    input  wire       raw_in,
    input  wire [7:0] pol,
    input  wire       en,
    output wire       active
);
    // normally-closed inputs are active when the line is low
    assign active = en & (raw_in ^ pol[0]);
endmodule

// >>> rtl/sstc_top.v
/*
 * safe-stop terminal configuration: ahb-lite register slave, terminal
 * function and polarity settings, emergency-stop trip latch, interrupt.
 * assumes a single 100 MHz clock, terminal inputs synchronous to it,
 * and an external safety circuit driving the terminal inputs.
 * hsize and the low address bits are ignored; only whole words are served.
 */
// Notes on behaviour
// - switch on reserves terminals 1 and 3 for emergency stop only
// - switch defaults off, emergency stop disabled
// - terminal 1 normally-open reset clears the trip and resets device
// - terminal 3 normally-closed input removal stops switching and latches trip
// - open wire or wrong logic on terminal 3 also trips
// - only terminal 1 reset clears the trip, keypad clear ignored
// - switch off: mappings selectable, defaults 18/06 with polarity 00
// - switch on: terminal 1 fixed 18/00, terminal 3 fixed 64/01, writes refused
// - turning switch off later restores nothing, only software reassigns
// - any terminal mapped to reset 18 has polarity forced to 00
// - terminal 3 holding code 64 has polarity forced to 01
// - switch on turns reset 18 on other terminals into no function
// - software cannot assign code 64; only the switch applies it
// - copy into switched-on device skips terminals 1 and 3, flags error
`timescale 1ns/10ps
`include "sstc_defines.vh"
module sstc_top #(
    parameter N_TERM = 8
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              hsel,
    input  wire [11:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire              hreadyout,
    output wire              hresp,
    output wire [31:0]       hrdata,
    input  wire              estop_enable_switch,
    input  wire [N_TERM-1:0] term_in,
    output wire              gate_enable,
    output wire [7:0]        estop_trip_code,
    output wire              device_reset,
    output wire [N_TERM-1:0] term_active,
    output wire              irq
);

    // ==========================================================
    // state
    reg                     hreadyout_ff;
    reg [31:0]              hrdata_ff;
    reg                     wr_pend_ff;
    reg                     rd_pend_ff;
    reg [11:0]              addr_ff;
    reg                     copy_mode_ff;
    reg [`SSTC_IRQ_W-1:0]   irq_stat_ff;
    reg [`SSTC_IRQ_W-1:0]   irq_mask_ff;
    reg                     irq_ff;
    reg                     sw_on_ff;
    reg                     eval_en_ff;
    reg                     trip_ff;
    reg                     gate_en_ff;
    reg [7:0]               trip_code_ff;
    reg                     dev_rst_ff;
    reg [N_TERM-1:0]        term_act_ff;
    reg [8*N_TERM-1:0]      func_ff;
    reg [8*N_TERM-1:0]      pol_ff;

    wire                    take;
    wire                    wr_en;
    wire                    term_hit;
    wire [3:0]              term_idx;
    wire                    sw_rise;
    wire [N_TERM-1:0]       act;
    wire [N_TERM-1:0]       refuse_vec;
    wire [N_TERM-1:0]       copyerr_vec;
    wire                    estop_req;
    wire                    reset_req;
    wire                    nxt_trip;
    reg  [31:0]             nxt_rdata;
    reg  [`SSTC_IRQ_W-1:0]  nxt_irq_stat;
    wire [31:0]             act_word;

    // ==========================================================
    // ahb-lite slave
    // one address phase is taken per rising edge with hready high
    assign take     = hsel & htrans[1] & hready;
    // writes land at the edge that ends their data phase
    assign wr_en    = wr_pend_ff;
    assign term_hit = (addr_ff[11:6] == `SSTC_TERM_REGION) && (addr_ff[5:2] < N_TERM);
    assign term_idx = addr_ff[5:2];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0000_0000;
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            addr_ff      <= 12'h000;
        end else begin
            wr_pend_ff <= take & hwrite;
            rd_pend_ff <= take & ~hwrite;
            if (take) begin
                addr_ff <= {haddr[11:2], 2'b00};
            end
            // reads take one wait state so a preceding write is visible
            if (take & ~hwrite) begin
                hreadyout_ff <= 1'b0;
            end else begin
                hreadyout_ff <= 1'b1;
            end
            if (rd_pend_ff) begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    // ==========================================================
    // read data select
    // terminal activity padded to a word, its low byte goes to status
    assign act_word = {{(32-N_TERM){1'b0}}, term_act_ff};

    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (term_hit) begin
            nxt_rdata[7:0]  = func_ff[8*term_idx +: 8];
            nxt_rdata[15:8] = pol_ff[8*term_idx +: 8];
        end else begin
            case (addr_ff)
                `SSTC_OFS_CTRL: begin
                    nxt_rdata[`SSTC_CTRL_COPY_BIT] = copy_mode_ff;
                end
                `SSTC_OFS_STATUS: begin
                    nxt_rdata[`SSTC_ST_TRIP_BIT] = trip_ff;
                    nxt_rdata[`SSTC_ST_SW_BIT]   = sw_on_ff;
                    nxt_rdata[`SSTC_ST_GATE_BIT] = gate_en_ff;
                    nxt_rdata[`SSTC_ST_EVAL_BIT] = eval_en_ff;
                    nxt_rdata[23:16]             = trip_code_ff;
                    nxt_rdata[31:24]             = act_word[7:0];
                end
                `SSTC_OFS_IRQ_STAT: begin
                    nxt_rdata[`SSTC_IRQ_W-1:0] = irq_stat_ff;
                end
                `SSTC_OFS_IRQ_MASK: begin
                    nxt_rdata[`SSTC_IRQ_W-1:0] = irq_mask_ff;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // switch sampling and evaluation enable
    // mapping is forced at the same edge that first sees the switch on
    assign sw_rise = estop_enable_switch & ~sw_on_ff;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_on_ff   <= 1'b0;
            eval_en_ff <= 1'b0;
        end else begin
            sw_on_ff   <= estop_enable_switch;
            eval_en_ff <= 1'b1;
        end
    end

    // ==========================================================
    // terminal settings and evaluation
    genvar i;
    generate
        for (i = 0; i < N_TERM; i = i + 1) begin : g_term
            localparam IS_T1 = (i == 0);
            localparam IS_T3 = (i == 2);
            localparam [7:0] RST_FN = IS_T1 ? `SSTC_FN_RESET :
                                      (IS_T3 ? `SSTC_FN_JOG : `SSTC_RST_FN_OTHER);
            wire       hit;
            wire       locked;
            wire       bad_fn;
            reg  [7:0] fc;
            reg  [7:0] pc;

            assign hit    = wr_en & term_hit & (term_idx == i);
            assign locked = sw_on_ff & (IS_T1 | IS_T3);
            assign bad_fn = (hwdata[7:0] == `SSTC_FN_ESTOP);
            assign refuse_vec[i]  = hit & ~(locked & copy_mode_ff) & (locked | bad_fn);
            assign copyerr_vec[i] = hit & locked & copy_mode_ff;

            always @* begin
                fc = func_ff[8*i +: 8];
                pc = pol_ff[8*i +: 8];
                // switch turning on forces the fixed mapping
                if (sw_rise) begin
                    if (IS_T1) begin
                        fc = `SSTC_FN_RESET;
                    end else if (IS_T3) begin
                        fc = `SSTC_FN_ESTOP;
                    end else if (fc == `SSTC_FN_RESET) begin
                        fc = `SSTC_FN_NONE;
                    end
                end else if (hit & ~locked & ~bad_fn) begin
                    fc = hwdata[7:0];
                    pc = hwdata[15:8];
                end
                // polarity forcing follows every update
                if (fc == `SSTC_FN_RESET) begin
                    pc = `SSTC_POL_NO;
                end else if (IS_T3 && fc == `SSTC_FN_ESTOP) begin
                    pc = `SSTC_POL_NC;
                end
            end

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    func_ff[8*i +: 8] <= RST_FN;
                    pol_ff[8*i +: 8]  <= `SSTC_POL_NO;
                end else begin
                    func_ff[8*i +: 8] <= fc;
                    pol_ff[8*i +: 8]  <= pc;
                end
            end

            sstc_term_eval u_eval (
                .raw_in (term_in[i]),
                .pol    (pol_ff[8*i +: 8]),
                .en     (eval_en_ff),
                .active (act[i])
            );
        end
    endgenerate

    // ==========================================================
    // emergency-stop trip
    // a low terminal 3 line (open, broken or wrong logic) reads as a request
    assign estop_req = sw_on_ff & eval_en_ff & act[2] &
                       (func_ff[23:16] == `SSTC_FN_ESTOP);
    assign reset_req = act[0] & (func_ff[7:0] == `SSTC_FN_RESET);
    // keypad clear writes never reach this term
    assign nxt_trip  = estop_req | (trip_ff & ~reset_req);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trip_ff      <= 1'b0;
            gate_en_ff   <= 1'b0;
            trip_code_ff <= 8'h00;
            dev_rst_ff   <= 1'b0;
            term_act_ff  <= {N_TERM{1'b0}};
        end else begin
            // trip code mirrors the latch so software sees both together
            trip_ff      <= nxt_trip;
            gate_en_ff   <= ~nxt_trip & eval_en_ff;
            trip_code_ff <= nxt_trip ? `SSTC_TRIP_CODE : 8'h00;
            dev_rst_ff   <= reset_req;
            term_act_ff  <= act;
        end
    end

    // ==========================================================
    // control, interrupt status and mask
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_en && addr_ff == `SSTC_OFS_IRQ_STAT) begin
            nxt_irq_stat = irq_stat_ff & ~hwdata[`SSTC_IRQ_W-1:0];
        end
        // set wins over a same-cycle clear
        nxt_irq_stat[`SSTC_IRQ_TRIP_BIT]   = nxt_irq_stat[`SSTC_IRQ_TRIP_BIT] | (nxt_trip & ~trip_ff);
        nxt_irq_stat[`SSTC_IRQ_COPY_BIT]   = nxt_irq_stat[`SSTC_IRQ_COPY_BIT] | (|copyerr_vec);
        nxt_irq_stat[`SSTC_IRQ_REFUSE_BIT] = nxt_irq_stat[`SSTC_IRQ_REFUSE_BIT] | (|refuse_vec);
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            copy_mode_ff <= 1'b0;
            irq_stat_ff  <= {`SSTC_IRQ_W{1'b0}};
            irq_mask_ff  <= `SSTC_RST_MASK;
            irq_ff       <= 1'b0;
        end else begin
            if (wr_en && addr_ff == `SSTC_OFS_CTRL) begin
                copy_mode_ff <= hwdata[`SSTC_CTRL_COPY_BIT];
            end
            if (wr_en && addr_ff == `SSTC_OFS_IRQ_MASK) begin
                irq_mask_ff <= hwdata[`SSTC_IRQ_W-1:0];
            end
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout       = hreadyout_ff;
    // every transfer completes with an okay response
    assign hresp           = 1'b0;
    assign hrdata          = hrdata_ff;
    assign gate_enable     = gate_en_ff;
    assign estop_trip_code = trip_code_ff;
    assign device_reset    = dev_rst_ff;
    assign term_active     = term_act_ff;
    assign irq             = irq_ff;

endmodule

// >>> verif/sstc_relay_model.sv
/*
 * relay model: external safety shutoff circuit wired to the terminals.
 * assumes levels are changed by the bench just after a rising clock edge.
 */
`timescale 1ns/10ps
module sstc_relay_model #(
    parameter N_TERM = 8
) (
    input  wire              estop_req,
    input  wire              wire_break,
    input  wire              reset_req,
    input  wire [N_TERM-1:0] other_in,
    output wire [N_TERM-1:0] term_in
);
    // ==========================================================
    // contacts
    // reset contact closes on request; stop chain opens on request or a cut wire
    assign term_in = {other_in[N_TERM-1:3], ~(estop_req | wire_break), other_in[1], reset_req};
endmodule

// >>> verif/sstc_top_asserts.sv
/*
 * checker: trip latch, terminal polarity and bus wait relations.
 * assumes binding into sstc_top, one clock hclk, async reset hresetn.
 */
`timescale 1ns/10ps
module sstc_top_asserts #(
    parameter N_TERM = 8
) (
    input wire              hclk,
    input wire              hresetn,
    input wire              hsel,
    input wire [1:0]        htrans,
    input wire              hwrite,
    input wire              hready,
    input wire              hreadyout,
    input wire              estop_enable_switch,
    input wire [N_TERM-1:0] term_in,
    input wire              gate_enable,
    input wire [7:0]        estop_trip_code,
    input wire              device_reset,
    input wire [N_TERM-1:0] term_active
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // switch held on for four edges
    reg  [2:0] sw_hist_ff;
    wire       sw_st = &{sw_hist_ff, estop_enable_switch};
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            sw_hist_ff <= 3'h0;
        else
            sw_hist_ff <= {sw_hist_ff[1:0], estop_enable_switch};
    // ==========================================================
    // properties
    code_vals_a:
        assert property (estop_trip_code == 8'h00 || estop_trip_code == 8'h25) else $error("bad trip code");
    trip_gate_a:
        assert property (estop_trip_code == 8'h25 |-> !gate_enable) else $error("gate on while tripped");
    trip_set_a:
        assert property (sw_st && !term_in[2] |=> estop_trip_code == 8'h25 && !gate_enable) else $error("no trip");
    trip_hold_a:
        assert property (estop_trip_code == 8'h25 && !term_in[0] |=> estop_trip_code == 8'h25) else $error("trip lost");
    trip_clr_a:
        assert property (sw_st && estop_trip_code == 8'h25 && term_in[0] && term_in[2]
            |=> estop_trip_code == 8'h00 && gate_enable) else $error("trip not cleared");
    dev_rst_a:
        assert property (sw_st && term_in[0] |=> device_reset) else $error("no device reset");
    rst_pol_a:
        assert property (sw_st |=> term_active[0] == $past(term_in[0])) else $error("terminal 1 polarity");
    nc_pol_a:
        assert property (sw_st |=> term_active[2] == !$past(term_in[2])) else $error("terminal 3 polarity");
    rd_wait_a:
        assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
endmodule
bind sstc_top sstc_top_asserts #(.N_TERM(N_TERM)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .estop_enable_switch(estop_enable_switch), .term_in(term_in), .gate_enable(gate_enable),
    .estop_trip_code(estop_trip_code), .device_reset(device_reset), .term_active(term_active));

// >>> verif/tb_top.sv
/*
 * testbench: drives sstc_top over ahb-lite and the relay model.
 * assumes design, relay model and checker compiled before it.
 */
`timescale 1ns/10ps
module tb_top;
    localparam N_TERM = 8;
    reg               hclk = 1'b0;
    reg               hresetn = 1'b0;
    reg               hsel = 1'b0;
    reg  [11:0]       haddr = 12'h000;
    reg  [1:0]        htrans = 2'h0;
    reg               hwrite = 1'b0;
    reg  [31:0]       hwdata = 32'h0;
    reg               sw = 1'b0;
    reg               estop_req = 1'b0;
    reg               wire_break = 1'b0;
    reg               reset_req = 1'b0;
    wire              hreadyout;
    wire [31:0]       hrdata;
    wire              gate_enable;
    wire [7:0]        trip_code;
    wire              device_reset;
    wire              irq;
    wire              hresp;
    wire [N_TERM-1:0] term_active;
    wire [N_TERM-1:0] term_in;
    reg  [31:0]       rd_q;
    integer           fails = 0;
    integer           samples_checked = 0;
    integer           cycles = 0;
    // ==========================================================
    // instances
    sstc_top #(.N_TERM(N_TERM)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .estop_enable_switch(sw), .term_in(term_in),
        .gate_enable(gate_enable), .estop_trip_code(trip_code), .device_reset(device_reset),
        .term_active(term_active), .irq(irq));
    sstc_relay_model #(.N_TERM(N_TERM)) i_relay (.estop_req(estop_req), .wire_break(wire_break),
        .reset_req(reset_req), .other_in(8'h00), .term_in(term_in));
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            test_done();
        end
    end
    // ==========================================================
    // helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge hclk);
    endtask
    task wt;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd_q = hrdata;
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
    endtask
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task pwr;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    // ==========================================================
    // scenarios
    task t_defaults;
        rchk("term1", 12'h040, 32'h0012);
        rchk("term3", 12'h048, 32'h0006);
        rchk("status", 12'h004, 32'h0400000c);
        chk("term act", 32'h4, {24'h0, term_active});
        rchk("unmapped", 12'h020, 32'h0);
        @(posedge hclk);
        estop_req <= 1'b1;
        cyc(3);
        chk("code off", 32'h0, {24'h0, trip_code});
        @(posedge hclk);
        estop_req <= 1'b0;
    endtask
    task t_irq;
        bus(1'b1, 12'h044, 32'h0112);
        rchk("pol forced", 12'h044, 32'h0012);
        bus(1'b1, 12'h048, 32'h0140);
        rchk("no 64", 12'h048, 32'h0006);
        cyc(1);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, 12'h00c, 32'h4);
        cyc(2);
        chk("irq on", 32'h1, {31'h0, irq});
        bus(1'b1, 12'h008, 32'h4);
        cyc(2);
        chk("irq clr", 32'h0, {31'h0, irq});
    endtask
    task t_on;
        @(posedge hclk);
        sw <= 1'b1;
        cyc(4);
        rchk("t1 fixed", 12'h040, 32'h0012);
        rchk("t2 none", 12'h044, 32'h00ff);
        rchk("t3 fixed", 12'h048, 32'h0140);
        bus(1'b1, 12'h040, 32'h0006);
        bus(1'b1, 12'h048, 32'h0006);
        rchk("t1 kept", 12'h040, 32'h0012);
        rchk("t3 kept", 12'h048, 32'h0140);
    endtask
    task t_trip;
        integer k;
        for (k = 0; k < 2; k = k + 1) begin
            @(posedge hclk);
            estop_req <= (k == 0);
            wire_break <= (k == 1);
            cyc(2);
            chk("trip", 32'h25, {24'h0, trip_code});
            chk("gate off", 32'h0, {31'h0, gate_enable});
            bus(1'b1, 12'h010, 32'h1);
            @(posedge hclk);
            estop_req <= 1'b0;
            wire_break <= 1'b0;
            cyc(3);
            chk("held", 32'h25, {24'h0, trip_code});
            @(posedge hclk);
            reset_req <= 1'b1;
            cyc(2);
            chk("dev reset", 32'h1, {31'h0, device_reset});
            @(posedge hclk);
            reset_req <= 1'b0;
            cyc(2);
            chk("gate on", 32'h1, {31'h0, gate_enable});
            chk("cleared", 32'h0, {24'h0, trip_code});
        end
    endtask
    task t_copy;
        bus(1'b1, 12'h000, 32'h1);
        bus(1'b1, 12'h040, 32'h0006);
        bus(1'b1, 12'h044, 32'h0006);
        rchk("copy skip", 12'h040, 32'h0012);
        rchk("copy other", 12'h044, 32'h0006);
        rchk("copy flag", 12'h008, 32'h7);
        pwr();
        rchk("map at start", 12'h048, 32'h0140);
    endtask
    task t_off;
        @(posedge hclk);
        sw <= 1'b0;
        cyc(4);
        rchk("t1 stays", 12'h040, 32'h0012);
        rchk("t3 stays", 12'h048, 32'h0140);
        bus(1'b1, 12'h040, 32'h0006);
        rchk("t1 user", 12'h040, 32'h0006);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        pwr();
        t_defaults();
        t_irq();
        t_on();
        t_trip();
        t_copy();
        t_off();
        test_done();
    end
endmodule
